// ### clk_mode_pkg.sv
// Constants, register map and state types for the clock and mode controller.
// Assumes a single 250 MHz reference clock and a 32-bit Avalon-MM register bus.
package clk_mode_pkg;
  // Register byte offsets
  localparam logic [3:0] MODE_OFS  = 4'h0;
  localparam logic [3:0] FLAGS_OFS = 4'h4;
  // Mode register fields
  localparam int MODE_DIV_LSB = 5;
  localparam int MODE_LSRDY   = 3;
  localparam int MODE_HSRDY   = 2;
  localparam int MODE_IDLEEN  = 1;
  localparam int MODE_FULL    = 0;
  // Flags register fields
  localparam int FLG_KEEP     = 7;
  localparam int FLG_FREQ_LSB = 4;
  localparam int FLG_LVR      = 2;
  localparam int FLG_GP       = 1;
  localparam int FLG_WDT      = 0;
  // Reset values
  localparam logic [2:0] DIV_RST     = 3'h0;
  localparam logic       IDLEEN_RST  = 1'h1;
  localparam logic       FULL_RST    = 1'h1;
  localparam logic [1:0] FREQ_RST    = 2'h0;
  // Divider codes at or above this select the divided fast clock
  localparam logic [2:0] DIV_FAST_MIN = 3'h2;
  // Oscillator edges counted before the ready flags rise
  localparam logic [3:0] FAST_READY_LAST = 4'hF;
  localparam logic       SLOW_READY_LAST = 1'h1;
  // Peripheral tap masks on the fast divider
  localparam logic [5:0] TAP16_MASK = 6'h0F;
  localparam logic [5:0] TAP64_MASK = 6'h3F;
  // Fast RC frequencies in MHz
  localparam logic [4:0] MHZ_8  = 5'h08;
  localparam logic [4:0] MHZ_12 = 5'h0C;
  localparam logic [4:0] MHZ_16 = 5'h10;

  typedef enum logic [3:0] {
    RUN          = 4'h1,
    SLEEP        = 4'h2,
    IDLE_STOPPED = 4'h4,
    IDLE_RUNNING = 4'h8
  } mode_e;

  typedef struct packed {
    mode_e      mode;
    logic [2:0] div_sel;
    logic       full_sel;
    logic       idle_en;
    logic       keep;
    logic [1:0] freq;
    logic       lvr_flag;
    logic       gp;
    logic       wdt_flag;
    logic       ls_ready;
    logic       hs_ready;
    logic [3:0] fast_cnt;
    logic       slow_cnt;
    logic       boot_done;
    logic       osc_en;
    logic [3:0] act_code;
    logic [5:0] div_cnt;
    logic       fast_prev;
    logic       slow_prev;
    logic       sys_tick;
    logic       tick16;
    logic       tick64;
    logic       ack;
    logic [7:0] rdata;
    logic       slverr;
  } state_s;
endpackage

// ### clk_mode_ctrl.sv
// System clock source, divider, oscillator readiness and halt mode controller.
// Assumes oscillator levels and event pulses are synchronous to REF_CLK_I.
// What this block does
// - Divider code picks slow or fast divided clock
// - Full-speed bit selects undivided fast clock
// - Fast oscillator stops once slow clock active
// - Slow ready flag rises after two slow edges
// - Fast ready flag after sixteen edges, low asleep
// - CPU held until fast ready after power-on
// - Halt enters idle or sleep by idle-enable
// - Idle keeps or stops system clock by bit
// - Unused bits ignore writes, read zero
// - Two-bit code sets fast RC frequency
// - Low-voltage flag set by event, software clears
// - General-purpose read/write bit, resets zero
// - Watchdog reset flag set, software clears
// - Divided peripheral clocks stop in slow mode
`timescale 1ns/10ps
`default_nettype none
module clk_mode_ctrl (
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic      [1:0]  AVS_RESPONSE_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        FAST_RC_CLK_I,
  input  wire logic        SLOW_RC_CLK_I,
  input  wire logic        HALT_I,
  input  wire logic        WAKE_I,
  input  wire logic        LVR_EVENT_I,
  input  wire logic        WDT_SOFT_RESET_I,
  output logic             FAST_OSC_EN_O,
  output logic      [4:0]  FAST_FREQ_MHZ_O,
  output logic             SYS_CLK_EN_O,
  output logic             PERIPH_DIV16_EN_O,
  output logic             PERIPH_DIV64_EN_O,
  output logic             CPU_RUN_O,
  output logic      [3:0]  MODE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Divider codes 2..7 use the fast clock
  function automatic logic is_fast(input logic [3:0] code);
    return code[3] | (code[2:0] >= clk_mode_pkg::DIV_FAST_MIN);
  endfunction

  // Code 2 divides by 64, code 7 by 2
  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    return clk_mode_pkg::TAP64_MASK >> (3'(sel - clk_mode_pkg::DIV_FAST_MIN));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  clk_mode_pkg::state_s s;
  clk_mode_pkg::state_s next_s;
  logic       fast_edge;
  logic       slow_edge;
  logic       running;
  logic [3:0] req_code;
  logic       req_ready;
  logic       wr_take;
  logic       sel_mode;
  logic       sel_flags;

  always_comb begin
    next_s      = s;
    running     = (s.mode == clk_mode_pkg::RUN) || (s.mode == clk_mode_pkg::IDLE_RUNNING);
    fast_edge   = FAST_RC_CLK_I & ~s.fast_prev & s.osc_en;
    slow_edge   = SLOW_RC_CLK_I & ~s.slow_prev;
    next_s.fast_prev = FAST_RC_CLK_I;
    next_s.slow_prev = SLOW_RC_CLK_I;
    req_code    = s.full_sel ? 4'h8 : {1'b0, s.div_sel};
    req_ready   = is_fast(req_code) ? s.hs_ready : s.ls_ready;

    // fast oscillator gating; off in sleep and stopped idle
    next_s.osc_en = running & (is_fast(req_code) | is_fast(s.act_code));

    if (!s.osc_en) begin
      next_s.hs_ready = 1'b0;
      next_s.fast_cnt = '0;
    end else if (fast_edge && !s.hs_ready) begin
      if (s.fast_cnt == clk_mode_pkg::FAST_READY_LAST) begin
        next_s.hs_ready = 1'b1;
      end else begin
        next_s.fast_cnt = s.fast_cnt + 4'h1;
      end
    end
    // boot completes on first fast ready
    if (s.hs_ready) begin
      next_s.boot_done = 1'b1;
    end

    // slow ready after two slow edges following wake
    if (!running) begin
      next_s.ls_ready = 1'b0;
      next_s.slow_cnt = 1'b0;
    end else if (slow_edge && !s.ls_ready) begin
      if (s.slow_cnt == clk_mode_pkg::SLOW_READY_LAST) begin
        next_s.ls_ready = 1'b1;
      end else begin
        next_s.slow_cnt = 1'b1;
      end
    end

    // hand over only to a ready source, restarting the divider
    if (fast_edge) begin
      next_s.div_cnt = s.div_cnt + 6'h01;
    end
    if (req_code != s.act_code && req_ready) begin
      next_s.act_code = req_code;
      next_s.div_cnt  = '0;
    end

    // source and ratio from the active code
    if (!running) begin
      next_s.sys_tick = 1'b0;
    end else if (s.act_code[3]) begin
      next_s.sys_tick = fast_edge;
    end else if (is_fast(s.act_code)) begin
      next_s.sys_tick = fast_edge &&
                        ((s.div_cnt & div_mask(s.act_code[2:0])) == div_mask(s.act_code[2:0]));
    end else begin
      next_s.sys_tick = slow_edge;
    end
    // taps die with the fast oscillator
    next_s.tick16 = fast_edge && ((s.div_cnt & clk_mode_pkg::TAP16_MASK) == clk_mode_pkg::TAP16_MASK);
    next_s.tick64 = fast_edge && (s.div_cnt == clk_mode_pkg::TAP64_MASK);

    // halt picks idle or sleep; keep bit picks idle flavour
    unique case (s.mode)
      clk_mode_pkg::RUN: begin
        if (HALT_I) begin
          if (!s.idle_en) begin
            next_s.mode = clk_mode_pkg::SLEEP;
          end else if (s.keep) begin
            next_s.mode = clk_mode_pkg::IDLE_RUNNING;
          end else begin
            next_s.mode = clk_mode_pkg::IDLE_STOPPED;
          end
        end
      end
      clk_mode_pkg::SLEEP, clk_mode_pkg::IDLE_STOPPED, clk_mode_pkg::IDLE_RUNNING: begin
        if (WAKE_I) begin
          next_s.mode = clk_mode_pkg::RUN;
        end
      end
    endcase

    // Bus: one wait cycle, then the answer
    sel_mode  = (AVS_ADDRESS_I == clk_mode_pkg::MODE_OFS);
    sel_flags = (AVS_ADDRESS_I == clk_mode_pkg::FLAGS_OFS);
    wr_take   = AVS_WRITE_I && s.ack && AVS_BYTEENABLE_I[0];
    next_s.ack = (AVS_READ_I || AVS_WRITE_I) && !s.ack;
    if ((AVS_READ_I || AVS_WRITE_I) && !s.ack) begin
      next_s.slverr = !(sel_mode || sel_flags);
      next_s.rdata  = '0;
      if (AVS_READ_I && sel_mode) begin
        next_s.rdata = {s.div_sel, 1'b0, s.ls_ready, s.hs_ready, s.idle_en, s.full_sel};
      end else if (AVS_READ_I && sel_flags) begin
        next_s.rdata = {s.keep, 1'b0, s.freq, 1'b0, s.lvr_flag, s.gp, s.wdt_flag};
      end
    end
    // writes land only on implemented bits
    if (wr_take && sel_mode) begin
      next_s.div_sel  = AVS_WRITEDATA_I[clk_mode_pkg::MODE_DIV_LSB +: 3];
      next_s.idle_en  = AVS_WRITEDATA_I[clk_mode_pkg::MODE_IDLEEN];
      next_s.full_sel = AVS_WRITEDATA_I[clk_mode_pkg::MODE_FULL];
    end
    if (wr_take && sel_flags) begin
      next_s.keep     = AVS_WRITEDATA_I[clk_mode_pkg::FLG_KEEP];
      next_s.freq     = AVS_WRITEDATA_I[clk_mode_pkg::FLG_FREQ_LSB +: 2];
      next_s.gp       = AVS_WRITEDATA_I[clk_mode_pkg::FLG_GP];
      next_s.lvr_flag = s.lvr_flag & AVS_WRITEDATA_I[clk_mode_pkg::FLG_LVR];
      next_s.wdt_flag = s.wdt_flag & AVS_WRITEDATA_I[clk_mode_pkg::FLG_WDT];
    end
    if (LVR_EVENT_I) begin
      next_s.lvr_flag = 1'b1;
    end
    if (WDT_SOFT_RESET_I) begin
      next_s.wdt_flag = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.mode     <= clk_mode_pkg::RUN;
      s.div_sel  <= clk_mode_pkg::DIV_RST;
      s.idle_en  <= clk_mode_pkg::IDLEEN_RST;
      s.full_sel <= clk_mode_pkg::FULL_RST;
      s.freq     <= clk_mode_pkg::FREQ_RST;
      s.act_code <= 4'h8;
      s.osc_en   <= 1'b1;  // Fast RC starts at power-on
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !s.ack;
  assign AVS_READDATA_O    = {24'h000000, s.rdata};
  assign AVS_RESPONSE_O    = s.slverr ? 2'h2 : 2'h0;
  assign FAST_OSC_EN_O     = s.osc_en;
  assign SYS_CLK_EN_O      = s.sys_tick;
  assign PERIPH_DIV16_EN_O = s.tick16;
  assign PERIPH_DIV64_EN_O = s.tick64;
  assign MODE_O            = s.mode;
  // CPU waits for first fast ready
  assign CPU_RUN_O = (s.mode == clk_mode_pkg::RUN) && s.boot_done;

  always_comb begin
    unique case (s.freq)
      2'h1:    FAST_FREQ_MHZ_O = clk_mode_pkg::MHZ_16;
      2'h2:    FAST_FREQ_MHZ_O = clk_mode_pkg::MHZ_12;
      default: FAST_FREQ_MHZ_O = clk_mode_pkg::MHZ_8;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_SLOW_SRC_OSC_OFF: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (running && !is_fast(s.act_code) && !is_fast(req_code)) |=> !FAST_OSC_EN_O)
    else $error("fast oscillator left on with slow source");
  AST_HS_READY_LOW_ASLEEP: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (s.mode == clk_mode_pkg::SLEEP) [*3] |-> !s.hs_ready)
    else $error("fast ready high in sleep");
  AST_CPU_NEEDS_READY: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (CPU_RUN_O && !$past(s.boot_done, 1)) |-> $past(s.hs_ready, 1))
    else $error("cpu ran before fast ready");
  AST_HALT_SLEEP: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (s.mode == clk_mode_pkg::RUN && HALT_I && !s.idle_en) |=> s.mode == clk_mode_pkg::SLEEP)
    else $error("halt did not enter sleep");
  AST_IDLE_STOP_NO_CLK: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (s.mode == clk_mode_pkg::IDLE_STOPPED) [*2] |-> !SYS_CLK_EN_O && !CPU_RUN_O)
    else $error("clock running in stopped idle");
  AST_LVR_STICKY: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (s.lvr_flag && !(wr_take && sel_flags)) |=> s.lvr_flag)
    else $error("low-voltage flag lost without write");
  AST_WDT_SET: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    WDT_SOFT_RESET_I |=> s.wdt_flag)
    else $error("watchdog flag not set");
  // Event must win over a same-cycle software clear
  AST_LVR_SET: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    LVR_EVENT_I |=> s.lvr_flag)
    else $error("low-voltage flag not set");
  AST_SLOW_READY_ASLEEP: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (s.mode == clk_mode_pkg::SLEEP) [*2] |-> !s.ls_ready)
    else $error("slow ready high in sleep");
  AST_HALT_IDLE_RUN: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (s.mode == clk_mode_pkg::RUN && HALT_I && s.idle_en && s.keep) |=>
      s.mode == clk_mode_pkg::IDLE_RUNNING)
    else $error("halt did not enter running idle");
  // Undivided source ticks on every fast edge
  AST_FULL_SPEED_TICK: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    (running && s.act_code[3]) |=> SYS_CLK_EN_O == $past(fast_edge, 1))
    else $error("full speed clock skipped a fast edge");
  AST_READY_SWITCH: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    ($changed(s.act_code) && is_fast(s.act_code)) |-> $past(s.hs_ready, 1))
    else $error("switched to unready fast source");
  AST_SLOW_TAPS_OFF: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    !s.osc_en |=> !PERIPH_DIV16_EN_O && !PERIPH_DIV64_EN_O)
    else $error("divided taps run with oscillator off");
  COV_SLEEP: cover property (@(posedge REF_CLK_I) disable iff (!rst_n)
    s.mode == clk_mode_pkg::SLEEP ##[1:50] s.mode == clk_mode_pkg::RUN);
  COV_IDLE_RUN: cover property (@(posedge REF_CLK_I) disable iff (!rst_n)
    s.mode == clk_mode_pkg::IDLE_RUNNING && SYS_CLK_EN_O);
  COV_SLOW: cover property (@(posedge REF_CLK_I) disable iff (!rst_n)
    s.act_code == 4'h0 && SYS_CLK_EN_O);
  COV_FAST_READY_WAKE: cover property (@(posedge REF_CLK_I) disable iff (!rst_n)
    $rose(s.hs_ready) && s.boot_done);

endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the clock source and halt mode controller.
// Assumes one wait cycle per bus request and oscillators sampled on the reference clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [3:0] M = clk_mode_pkg::MODE_OFS;
  localparam logic [3:0] F = clk_mode_pkg::FLAGS_OFS;
  logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [3:0]  addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0, v;
  logic        frc = 1'b0, src = 1'b0, halt = 1'b0, wake = 1'b0, lvr = 1'b0, wdt = 1'b0;
  logic [2:0]  sdiv = 3'h0;
  logic [1:0]  r;
  wire  [31:0] rdata;
  wire  [1:0]  resp;
  wire         wreq, osc_en, sys_en, d16, d64, cpu_run;
  wire  [4:0]  mhz;
  wire  [3:0]  mode;
  int          n_errors = 0, n_checks = 0, c_sys, c16, c64;
  ////////////////////////////////////////////////////////////////////////////////
  // Reference clock, 4 ns
  always #2 clk = ~clk;
  // Fast oscillator only toggles while enabled, so its readiness must restart
  always @(posedge clk) begin
    if (osc_en === 1'b1) frc <= ~frc;
    sdiv <= sdiv + 3'h1;
    if (sdiv == 3'h7) src <= ~src;
  end
  clk_mode_ctrl DUT (.REF_CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_RESPONSE_O(resp), .AVS_WAITREQUEST_O(wreq),
    .FAST_RC_CLK_I(frc), .SLOW_RC_CLK_I(src), .HALT_I(halt), .WAKE_I(wake),
    .LVR_EVENT_I(lvr), .WDT_SOFT_RESET_I(wdt), .FAST_OSC_EN_O(osc_en),
    .FAST_FREQ_MHZ_O(mhz), .SYS_CLK_EN_O(sys_en), .PERIPH_DIV16_EN_O(d16),
    .PERIPH_DIV64_EN_O(d64), .CPU_RUN_O(cpu_run), .MODE_O(mode));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low, then a spare edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      t++;
    end while (wreq !== 1'b0 && t < 50);
    if (t >= 50) chk("waitrequest", 32'h0, 32'h1);
    v = rdata;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Pulse counting over a window; waiting on ready is bounded
  task automatic cnt(input int n);
    c_sys = 0; c16 = 0; c64 = 0;
    repeat (n) begin
      @(posedge clk);
      if ($isunknown({sys_en, d16, d64})) chk("pulse level", 32'h0, 32'h1);
      c_sys += sys_en; c16 += d16; c64 += d64;
    end
  endtask
  task automatic poll_fast();
    int t;
    t = 0;
    do begin
      bus(1'b0, M, 32'h0);
      t++;
    end while (v[2] !== 1'b1 && t < 40);
    chk("fast ready", 32'h1, {31'h0, v[2]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_boot();
    int t;
    t = 0;
    while (cpu_run !== 1'b1 && t < 200) begin
      @(posedge clk);
      t++;
    end
    bus(1'b0, M, 32'h0);
    chk("boot fast ready", 32'h1, {31'h0, v[2]});
    repeat (40) @(posedge clk);
    bus(1'b0, M, 32'h0);
    chk("mode reset", 32'h0F, v);
    bus(1'b0, F, 32'h0);
    chk("flags reset", 32'h00, v);
  endtask
  task automatic t_regs();
    bus(1'b1, M, 32'hFFFF_FFFF);
    bus(1'b0, M, 32'h0);
    chk("mode unused bits", 32'hEF, v);
    bus(1'b1, F, 32'hFFFF_FFFF);
    bus(1'b0, F, 32'h0);
    chk("flags unused bits", 32'hB2, v);
    be <= 4'h0;
    bus(1'b1, F, 32'h0);
    be <= 4'hF;
    bus(1'b0, F, 32'h0);
    chk("lane off write", 32'hB2, v);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped response", 32'h2, {30'h0, r});
    chk("unmapped data", 32'h0, v);
    bus(1'b1, M, 32'h03);
  endtask
  task automatic t_freq();
    logic [4:0] tbl [4] = '{5'h08, 5'h10, 5'h0C, 5'h08};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, F, {26'h0, i[1:0], 4'h0});
      chk("fast frequency", {27'h0, tbl[i]}, {27'h0, mhz});
    end
  endtask
  task automatic t_flags();
    lvr <= 1'b1;
    wdt <= 1'b1;
    @(posedge clk);
    lvr <= 1'b0;
    wdt <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b0, F, 32'h0);
    chk("flags set", 32'h35, v);
    bus(1'b1, F, 32'h05);
    bus(1'b0, F, 32'h0);
    chk("flags kept", 32'h05, v);
    bus(1'b1, F, 32'h01);
    bus(1'b0, F, 32'h0);
    chk("lvr cleared", 32'h01, v);
    bus(1'b1, F, 32'h00);
    bus(1'b0, F, 32'h0);
    chk("wdt cleared", 32'h00, v);
  endtask
  task automatic t_div();
    for (int k = 7; k >= 0; k--) begin
      if (k < 2) begin
        bus(1'b0, M, 32'h0);
        chk("slow ready", 32'h1, {31'h0, v[3]});
      end
      bus(1'b1, M, {24'h0, k[2:0], 5'h02});
      repeat (40) @(posedge clk);
      cnt(512);
      if (k >= 2) begin
        rng("divided clock", (256 >> (8 - k)) - 1, (256 >> (8 - k)) + 1, c_sys);
      end else begin
        rng("slow clock", 31, 33, c_sys);
        chk("fast osc off", 32'h0, {31'h0, osc_en});
        rng("div16 stopped", 0, 0, c16);
        rng("div64 stopped", 0, 0, c64);
      end
    end
    bus(1'b1, M, 32'hE3);
    poll_fast();
    repeat (16) @(posedge clk);
    cnt(512);
    rng("full speed", 255, 257, c_sys);
    rng("div16 taps", 15, 17, c16);
    rng("div64 taps", 3, 5, c64);
  endtask
  task automatic t_halt(input logic ien, input logic keep, input logic [3:0] em);
    bus(1'b1, F, {24'h0, keep, 7'h0});
    bus(1'b1, M, {30'h0, ien, 1'b1});
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    repeat (3) @(posedge clk);
    chk("halt mode", {28'h0, em}, {28'h0, mode});
    chk("cpu stopped", 32'h0, {31'h0, cpu_run});
    cnt(64);
    rng("idle sys clock", (em == 4'h8) ? 31 : 0, (em == 4'h8) ? 33 : 0, c_sys);
    bus(1'b0, M, 32'h0);
    if (em != 4'h8) chk("asleep fast ready", 32'h0, {31'h0, v[2]});
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    chk("woken mode", 32'h1, {28'h0, mode});
    poll_fast();
    chk("cpu runs", 32'h1, {31'h0, cpu_run});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog sized well above the roughly 6k cycles of the sequence
  initial begin
    #160000;
    n_errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_boot();
    t_regs();
    t_freq();
    t_flags();
    t_div();
    t_halt(1'b0, 1'b0, 4'h2);
    t_halt(1'b0, 1'b1, 4'h2);
    t_halt(1'b1, 1'b0, 4'h4);
    t_halt(1'b1, 1'b1, 4'h8);
    finish_test();
  end
endmodule
`default_nettype wire
